// ---- include/hb_protect_pkg.sv ----
package hb_protect_pkg;

	// register addresses on the serial register port
	localparam logic [7:0] ADDR_PROT_CTRL = 8'h2E;
	localparam logic [7:0] ADDR_STA_LOW = 8'h2F;
	localparam logic [7:0] ADDR_STA_HIGH = 8'h3F;

	// field positions in the protection control register
	localparam int BIT_OCP_LEVEL = 7;
	localparam int BIT_OVP_LEVEL = 6;
	localparam int BIT_DCH_LEVEL = 5;
	localparam int BIT_TDEAD_SRC = 4;
	localparam int BIT_FAST_B12 = 3;
	localparam int BIT_FAST_B11 = 2;
	localparam int BIT_FAST_B10 = 1;
	localparam int BIT_FAST_B9 = 0;

	// trim field loaded from one-time memory, bits 7..4
	localparam int TRIM_LSB = 4;
	localparam int TRIM_WIDTH = 4;

	// bridge counts per status register
	localparam int STA_LOW_WIDTH = 8;
	localparam int STA_HIGH_WIDTH = 4;
	localparam int BRIDGE_COUNT = 12;

	// reset values
	localparam logic [7:0] PROT_CTRL_RESET = 8'h10;
	localparam logic [7:0] STA_RESET = 8'h00;
	localparam logic [3:0] STA_HIGH_RSVD = 4'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// life phase: one cycle of trim loading after reset, then run
	typedef enum logic [1:0] {
		PH_TRIM_LOAD = 2'h0,
		PH_RUN = 2'h1
	} phase_t;

endpackage

// ---- src/sticky_flag_bank.sv ----
`timescale 1ns/10ps

module sticky_flag_bank #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] set_event,
	output logic [WIDTH-1:0] flags
);

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} bank_state_t;

	bank_state_t state;
	bank_state_t next_state;

	// flags only rise; nothing but reset lowers them
	always_comb begin
		next_state = state;
		next_state.flags = state.flags | set_event;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state.flags <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flags = state.flags;

	// flag 0, once raised, must survive at least the next eight edges
	a_flag_holds: assert property (
		@(posedge ref_clk) disable iff (rst)
		$rose(flags[0]) |=> flags[0] [*8])
		else $error("raised flag dropped before reset");

	a_flag_rises: assert property (
		@(posedge ref_clk) disable iff (rst)
		set_event[WIDTH-1] |=> flags[WIDTH-1])
		else $error("event did not raise its flag");

endmodule

// ---- src/hb_protect_regs.sv ----
`timescale 1ns/10ps


module hb_protect_regs (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] otp_trim,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] hs_timeout_event,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic overcurrent_level_select,
	output logic overvoltage_level_select,
	output logic discharge_strength_select,
	output logic deadtime_feedback_select,
	output logic bridge12_offdiag_fast_charge,
	output logic bridge11_offdiag_fast_charge,
	output logic bridge10_offdiag_fast_charge,
	output logic bridge9_offdiag_fast_charge,
	output logic [11:0] drive_timeout_flags
);

	typedef struct packed {
		hb_protect_pkg::phase_t phase;
		logic [7:0] prot_ctrl;
		logic [7:0] rdata;
		logic rvalid;
	} regs_state_t;

	regs_state_t state;
	regs_state_t next_state;
	logic [7:0] flags_low;
	logic [3:0] flags_high;
	logic [7:0] sta_high_word;
	logic ctrl_write;

	// timeout flags, one sticky bank per status register
	sticky_flag_bank #(
		.WIDTH(hb_protect_pkg::STA_LOW_WIDTH)
	) u_flags_low (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_event(hs_timeout_event[7:0]),
		.flags(flags_low)
	);

	sticky_flag_bank #(
		.WIDTH(hb_protect_pkg::STA_HIGH_WIDTH)
	) u_flags_high (
		.ref_clk(ref_clk),
		.rst(rst),
		.set_event(hs_timeout_event[11:8]),
		.flags(flags_high)
	);

	// reserved nibble is forced, so no flop stands behind it
	assign sta_high_word = {hb_protect_pkg::STA_HIGH_RSVD, flags_high};

	// writes are refused during the trim load cycle so the trim wins
	assign ctrl_write = reg_wr && (reg_addr == hb_protect_pkg::ADDR_PROT_CTRL)
		&& (state.phase == hb_protect_pkg::PH_RUN);

	// next state: trim load, control write, read capture
	always_comb begin
		next_state = state;
		next_state.rvalid = reg_rd;
		case (state.phase)
			hb_protect_pkg::PH_TRIM_LOAD: begin
				next_state.prot_ctrl[hb_protect_pkg::TRIM_LSB +:
					hb_protect_pkg::TRIM_WIDTH] = otp_trim;
				next_state.phase = hb_protect_pkg::PH_RUN;
			end
			hb_protect_pkg::PH_RUN: begin
				if (ctrl_write) begin
					next_state.prot_ctrl = reg_wdata;
				end
			end
			default: begin
				next_state.phase = hb_protect_pkg::PH_TRIM_LOAD;
			end
		endcase
		// status addresses take no write path at all
		if (reg_rd) begin
			case (reg_addr)
				hb_protect_pkg::ADDR_PROT_CTRL: begin
					next_state.rdata = state.prot_ctrl;
				end
				hb_protect_pkg::ADDR_STA_LOW: begin
					next_state.rdata = flags_low;
				end
				hb_protect_pkg::ADDR_STA_HIGH: begin
					next_state.rdata = sta_high_word;
				end
				default: begin
					next_state.rdata = hb_protect_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	// synchronous reset; trim pins are sampled one cycle later, not here
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state.phase <= hb_protect_pkg::PH_TRIM_LOAD;
			state.prot_ctrl <= hb_protect_pkg::PROT_CTRL_RESET;
			state.rdata <= hb_protect_pkg::STA_RESET;
			state.rvalid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// every output below is a flop of the state or of a flag bank
	assign reg_rdata = state.rdata;
	assign reg_rvalid = state.rvalid;
	assign overcurrent_level_select =
		state.prot_ctrl[hb_protect_pkg::BIT_OCP_LEVEL];
	assign overvoltage_level_select =
		state.prot_ctrl[hb_protect_pkg::BIT_OVP_LEVEL];
	assign discharge_strength_select =
		state.prot_ctrl[hb_protect_pkg::BIT_DCH_LEVEL];
	assign deadtime_feedback_select =
		state.prot_ctrl[hb_protect_pkg::BIT_TDEAD_SRC];
	assign bridge12_offdiag_fast_charge =
		state.prot_ctrl[hb_protect_pkg::BIT_FAST_B12];
	assign bridge11_offdiag_fast_charge =
		state.prot_ctrl[hb_protect_pkg::BIT_FAST_B11];
	assign bridge10_offdiag_fast_charge =
		state.prot_ctrl[hb_protect_pkg::BIT_FAST_B10];
	assign bridge9_offdiag_fast_charge =
		state.prot_ctrl[hb_protect_pkg::BIT_FAST_B9];
	assign drive_timeout_flags = {flags_high, flags_low};

	// named steps of a control access
	sequence s_ctrl_write;
		reg_wr && (reg_addr == hb_protect_pkg::ADDR_PROT_CTRL)
			&& (state.phase == hb_protect_pkg::PH_RUN);
	endsequence

	sequence s_read_at(logic [7:0] a);
		reg_rd && (reg_addr == a);
	endsequence

	// a write that arrives while the trim is still being loaded
	sequence s_trim_write;
		(state.phase == hb_protect_pkg::PH_TRIM_LOAD) && reg_wr;
	endsequence

	// reset values need no disable: they are checked during reset itself
	a_reset_control: assert property (
		@(posedge ref_clk) rst |=>
		{overcurrent_level_select, overvoltage_level_select,
		discharge_strength_select, deadtime_feedback_select,
		bridge12_offdiag_fast_charge, bridge11_offdiag_fast_charge,
		bridge10_offdiag_fast_charge, bridge9_offdiag_fast_charge}
		== hb_protect_pkg::PROT_CTRL_RESET)
		else $error("control outputs not at reset value");

	a_reset_flags: assert property (
		@(posedge ref_clk) rst |=>
		drive_timeout_flags == 12'h000 && !reg_rvalid)
		else $error("flags or read valid not cleared by reset");

	// trim is taken once; a write in that cycle is dropped
	a_trim_load: assert property (
		@(posedge ref_clk) disable iff (rst)
		state.phase == hb_protect_pkg::PH_TRIM_LOAD |=>
		{overcurrent_level_select, overvoltage_level_select,
		discharge_strength_select, deadtime_feedback_select}
		== $past(otp_trim))
		else $error("trim bits not loaded after reset");

	a_trim_refuse: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_trim_write |=> {bridge12_offdiag_fast_charge,
		bridge11_offdiag_fast_charge, bridge10_offdiag_fast_charge,
		bridge9_offdiag_fast_charge} == $past(state.prot_ctrl[3:0]))
		else $error("write landed during the trim cycle");

	a_trim_once: assert property (
		@(posedge ref_clk) disable iff (rst)
		state.phase == hb_protect_pkg::PH_RUN |=>
		state.phase == hb_protect_pkg::PH_RUN)
		else $error("trim reloaded without a reset");

	// each field follows the bit written to it
	a_ocp_select: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write |=> overcurrent_level_select == $past(reg_wdata[7]))
		else $error("overcurrent select not taken from bit 7");

	a_ovp_select: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write |=> overvoltage_level_select == $past(reg_wdata[6]))
		else $error("overvoltage select not taken from bit 6");

	a_dch_select: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write |=> discharge_strength_select == $past(reg_wdata[5]))
		else $error("discharge select not taken from bit 5");

	a_tdead_select: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write |=> deadtime_feedback_select == $past(reg_wdata[4]))
		else $error("dead time select not taken from bit 4");

	a_fast_charge: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write |=> {bridge12_offdiag_fast_charge,
		bridge11_offdiag_fast_charge, bridge10_offdiag_fast_charge,
		bridge9_offdiag_fast_charge} == $past(reg_wdata[3:0]))
		else $error("fast charge bits not taken from bits 3..0");

	// control outputs hold between accepted writes
	a_ctrl_holds: assert property (
		@(posedge ref_clk) disable iff (rst)
		state.phase == hb_protect_pkg::PH_RUN && !ctrl_write
		|=> $stable(state.prot_ctrl))
		else $error("control register changed without a write");

	a_ctrl_readback: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_ctrl_write ##1 s_read_at(hb_protect_pkg::ADDR_PROT_CTRL)
		|=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
		else $error("control register does not read back");

	// read port: valid is a one-cycle echo of the strobe
	a_rvalid_pulse: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd |=> reg_rvalid)
		else $error("read strobe not answered next cycle");

	a_rvalid_drop: assert property (
		@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> !reg_rvalid)
		else $error("read valid without a read strobe");

	a_rdata_holds: assert property (
		@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	a_unmapped_read: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr != hb_protect_pkg::ADDR_PROT_CTRL
		&& reg_addr != hb_protect_pkg::ADDR_STA_LOW
		&& reg_addr != hb_protect_pkg::ADDR_STA_HIGH
		|=> reg_rdata == hb_protect_pkg::UNMAPPED_READ)
		else $error("unmapped address did not read zero");

	// status reads and the flags behind them
	a_low_status: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_read_at(hb_protect_pkg::ADDR_STA_LOW)
		|=> reg_rdata == $past(drive_timeout_flags[7:0]))
		else $error("low status read mismatch");

	a_high_status: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_read_at(hb_protect_pkg::ADDR_STA_HIGH)
		|=> reg_rdata == {4'h0, $past(drive_timeout_flags[11:8])})
		else $error("high status read mismatch");

	a_rsvd_zero: assert property (
		@(posedge ref_clk) disable iff (rst)
		s_read_at(hb_protect_pkg::ADDR_STA_HIGH)
		|=> reg_rdata[7:4] == 4'h0)
		else $error("reserved status bits not zero");

	a_low_flag_set: assert property (
		@(posedge ref_clk) disable iff (rst)
		hs_timeout_event[7:0] != 8'h00 |=> (drive_timeout_flags[7:0]
		& $past(hs_timeout_event[7:0])) == $past(hs_timeout_event[7:0]))
		else $error("low timeout event did not raise its flag");

	a_high_flag_set: assert property (
		@(posedge ref_clk) disable iff (rst)
		hs_timeout_event[11:8] != 4'h0 |=> (drive_timeout_flags[11:8]
		& $past(hs_timeout_event[11:8])) == $past(hs_timeout_event[11:8]))
		else $error("high timeout event did not raise its flag");

	// status registers have no write path at either address
	a_status_no_write: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_wr && (reg_addr == hb_protect_pkg::ADDR_STA_LOW)
		&& (hs_timeout_event == 12'h000)
		|=> $stable(drive_timeout_flags))
		else $error("status register changed by a write");

	a_status_hi_nowr: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_wr && (reg_addr == hb_protect_pkg::ADDR_STA_HIGH)
		&& (hs_timeout_event == 12'h000)
		|=> $stable(drive_timeout_flags))
		else $error("high status register changed by a write");

	a_flags_sticky: assert property (
		@(posedge ref_clk) disable iff (rst)
		drive_timeout_flags[11] |=> drive_timeout_flags[11])
		else $error("bridge 12 timeout flag cleared without reset");

endmodule

// ---- testbench/hb_host_model.sv ----
`timescale 1ns/10ps

module hb_host_model (
	input wire logic ref_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle bus shows inverted leftovers, never a stale valid-looking value
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one-cycle write strobe, launched off the falling edge
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask

	// answer lands one edge after the strobe; taken at the next low phase
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
		output logic ok);
		@(negedge ref_clk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~addr;
		data = reg_rdata;
		ok = reg_rvalid;
	endtask

	// write, then a read of the same address on the very next edge
	task automatic write_read(input logic [7:0] addr,
		input logic [7:0] wdat, output logic [7:0] data, output logic ok);
		@(negedge ref_clk);
		reg_addr = addr;
		reg_wdata = wdat;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~wdat;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~addr;
		data = reg_rdata;
		ok = reg_rvalid;
	endtask
endmodule

// ---- testbench/hb_protect_cfg_timeout_status_tb.sv ----
`timescale 1ns/10ps

module hb_protect_cfg_timeout_status_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] otp_trim = 4'hA;
	logic [11:0] hs_timeout_event = 12'h000;
	wire logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl;
	wire logic reg_wr, reg_rd, reg_rvalid;
	wire logic [11:0] flags;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] rd_data;
	logic rd_ok;

	always #5 ref_clk = ~ref_clk;

	hb_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	hb_protect_regs dut (.ref_clk(ref_clk), .rst(rst), .otp_trim(otp_trim),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .hs_timeout_event(hs_timeout_event),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.overcurrent_level_select(ctl[7]), .overvoltage_level_select(ctl[6]),
		.discharge_strength_select(ctl[5]), .deadtime_feedback_select(ctl[4]),
		.bridge12_offdiag_fast_charge(ctl[3]),
		.bridge11_offdiag_fast_charge(ctl[2]),
		.bridge10_offdiag_fast_charge(ctl[1]),
		.bridge9_offdiag_fast_charge(ctl[0]), .drive_timeout_flags(flags));

	task automatic complete_run();
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard: whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
		host.read_reg(addr, rd_data, rd_ok);
		check({11'h000, rd_ok}, 12'h001);
		check({4'h0, rd_data}, {4'h0, exp});
	endtask

	// trim load needs one edge after release before outputs settle
	task automatic do_reset(input logic [3:0] trim);
		otp_trim = trim;
		rst = 1'b1;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic test_defaults();
		logic [3:0] trim;
		for (int i = 0; i < 2; i++) begin
			trim = i ? 4'hA : 4'h5;
			do_reset(trim);
			check({4'h0, ctl}, {4'h0, trim, 4'h0});
			read_check(hb_protect_pkg::ADDR_PROT_CTRL, {trim, 4'h0});
			read_check(hb_protect_pkg::ADDR_STA_LOW, 8'h00);
			read_check(hb_protect_pkg::ADDR_STA_HIGH, 8'h00);
		end
	endtask

	// walking one shows each control field lands on its own output
	task automatic test_control_bits();
		for (int i = 0; i < 8; i++) begin
			host.write_reg(hb_protect_pkg::ADDR_PROT_CTRL, 8'h01 << i);
			check({4'h0, ctl}, 12'h001 << i);
			read_check(hb_protect_pkg::ADDR_PROT_CTRL, 8'h01 << i);
		end
	endtask

	task automatic test_refused();
		host.write_reg(hb_protect_pkg::ADDR_PROT_CTRL, 8'h5A);
		host.write_reg(hb_protect_pkg::ADDR_STA_LOW, 8'hFF);
		host.write_reg(hb_protect_pkg::ADDR_STA_HIGH, 8'hFF);
		host.write_reg(8'h40, 8'h33);
		check({4'h0, ctl}, 12'h05A);
		read_check(hb_protect_pkg::ADDR_STA_LOW, 8'h00);
		read_check(hb_protect_pkg::ADDR_STA_HIGH, 8'h00);
		read_check(8'h40, 8'h00);
	endtask

	// one-cycle pulses; earlier flags must survive every later step until the final reset clears them
	task automatic test_flags();
		logic [11:0] exp;
		exp = 12'h000;
		for (int i = 0; i < 12; i++) begin
			@(negedge ref_clk);
			hs_timeout_event = 12'h001 << i;
			@(negedge ref_clk);
			hs_timeout_event = 12'h000;
			exp = exp | (12'h001 << i);
			check(flags, exp);
			read_check(hb_protect_pkg::ADDR_STA_LOW, exp[7:0]);
			read_check(hb_protect_pkg::ADDR_STA_HIGH, {4'h0, exp[11:8]});
		end
		host.write_reg(hb_protect_pkg::ADDR_STA_LOW, 8'h00);
		host.write_reg(hb_protect_pkg::ADDR_STA_HIGH, 8'h00);
		check(flags, 12'hFFF);
		do_reset(4'h1);
		check(flags, 12'h000);
		check({4'h0, ctl}, 12'h010);
	endtask

	// write then read on the next edge: the read sees the new word
	task automatic test_back_to_back();
		host.write_read(hb_protect_pkg::ADDR_PROT_CTRL, 8'h96,
			rd_data, rd_ok);
		check({11'h000, rd_ok}, 12'h001);
		check({4'h0, rd_data}, 12'h096);
	endtask

	// a write in the trim cycle is dropped; reset shows the default word
	task automatic test_trim_refused();
		otp_trim = 4'h6;
		rst = 1'b1;
		repeat (9) @(negedge ref_clk);
		check({4'h0, ctl}, 12'h010);
		fork
			host.write_reg(hb_protect_pkg::ADDR_PROT_CTRL, 8'hFF);
			@(negedge ref_clk) rst = 1'b0;
		join
		check({4'h0, ctl}, 12'h060);
		host.write_reg(hb_protect_pkg::ADDR_PROT_CTRL, 8'hC3);
		check({4'h0, ctl}, 12'h0C3);
	endtask

	initial begin
		test_defaults();
		test_control_bits();
		test_refused();
		test_back_to_back();
		test_flags();
		test_trim_refused();
		complete_run();
	end
endmodule
